/* File: dbpio_pkg.sv */
package dbpio_pkg;
   localparam logic [7:0] DBPIO_OFS_PORT61 = 8'h00;
   localparam logic [7:0] DBPIO_OFS_PORTE1 = 8'h04;
   localparam logic [7:0] DBPIO_OFS_PORT70 = 8'h08;
   localparam logic [7:0] DBPIO_OFS_VIDEO = 8'h0C;
   localparam logic [7:0] DBPIO_OFS_STATUS = 8'h10;
   localparam logic [7:0] DBPIO_OFS_SETUP0 = 8'h20;
   localparam logic [7:0] DBPIO_OFS_DECODE0 = 8'h24;
   localparam logic [7:0] DBPIO_OFS_DEC_STRIDE = 8'h08;
   localparam int DBPIO_NUM_DEC = 3;
   localparam int DBPIO_P61_PARITY_EN = 2;
   localparam int DBPIO_P61_CHAN_EN = 3;
   localparam int DBPIO_P61_CHAN_STAT = 6;
   localparam int DBPIO_P61_PARITY_STAT = 7;
   localparam int DBPIO_E1_CHECK_EN = 0;
   localparam int DBPIO_P70_NMI_MASK = 7;
   localparam int DBPIO_VID_ENABLE = 0;
   localparam int DBPIO_VID_SETUP = 1;
   localparam int DBPIO_SET_ENABLE = 0;
   localparam int DBPIO_SET_LOW_MASK = 1;
   localparam int DBPIO_SET_UPPER_EXT = 2;
   localparam int DBPIO_SET_WRITE_ONLY = 3;
   localparam int DBPIO_SET_READ_ONLY = 4;
   localparam logic [7:0] DBPIO_P61_RESET = 8'h00;
   localparam logic [7:0] DBPIO_E1_RESET = 8'h00;
   localparam logic [7:0] DBPIO_P70_RESET = 8'h80;
   localparam logic [7:0] DBPIO_VID_RESET = 8'h01;
   localparam logic [16:0] DBPIO_IO_KBD_DATA = 17'h0_0060;
   localparam logic [16:0] DBPIO_IO_KBD_CMD = 17'h0_0064;
   localparam logic [16:0] DBPIO_IO_CMOS_LO = 17'h0_0074;
   localparam logic [16:0] DBPIO_IO_CMOS_HI = 17'h0_0075;
   localparam logic [1:0] DBPIO_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] DBPIO_AC_STRAIGHT = 2'h0;
   localparam logic [31:0] DBPIO_ZERO_WORD = 32'h0000_0000;

   typedef struct packed
   {
      logic [7:0] setup;
      logic [9:0] addr;
   } dbpio_dec_cfg_t;

   typedef struct packed
   {
      logic [16:0] addr;
      logic rd_n;
      logic wr_n;
      logic upper_ok_n;
   } dbpio_xbus_t;

   typedef enum logic [1:0]
   {
      CLR_IDLE,
      CLR_E1_SET,
      CLR_E1_DONE,
      CLR_P61_SET
   } dbpio_clr_state_t;

   // Odd parity bit for one byte: high when ones are even
   function automatic logic dbpio_parity_bit(input logic [7:0] b);
      dbpio_parity_bit = ~(^b);
   endfunction : dbpio_parity_bit
endpackage : dbpio_pkg

/* File: dbpio_prog_decode.sv */
module dbpio_prog_decode
   import dbpio_pkg::*;
(
   input wire dbpio_dec_cfg_t cfg,
   input wire dbpio_xbus_t xbus,
   output logic hit
);
   logic [9:0] care;
   logic addr_ok;
   logic upper_ok;
   logic dir_ok;

   always_comb
   begin
      care = 10'h3FF;
      if (cfg.setup[DBPIO_SET_LOW_MASK])
      begin
         care = 10'h3F8;
      end
      addr_ok = ((xbus.addr[9:0] ^ cfg.addr) & care) == 10'h000;
      if (cfg.setup[DBPIO_SET_UPPER_EXT])
      begin
         upper_ok = !xbus.upper_ok_n;
      end
      else
      begin
         upper_ok = xbus.addr[16:10] == 7'h00;
      end
      if (cfg.setup[DBPIO_SET_WRITE_ONLY])
      begin
         dir_ok = !xbus.wr_n;
      end
      else if (cfg.setup[DBPIO_SET_READ_ONLY])
      begin
         dir_ok = !xbus.rd_n;
      end
      else
      begin
         dir_ok = !xbus.rd_n || !xbus.wr_n;
      end
      hit = cfg.setup[DBPIO_SET_ENABLE] && addr_ok && upper_ok && dir_ok;
   end
endmodule : dbpio_prog_decode

/* File: dbpio_top.sv */
module dbpio_top
   import dbpio_pkg::*;
#(
   parameter int NUM_DEC = DBPIO_NUM_DEC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic system_reset,
   input wire logic [16:0] periph_addr_bit,
   input wire logic periph_io_read_n,
   input wire logic periph_io_write_n,
   input wire logic upper_addr_qualify_n,
   input wire logic action_code_hi,
   input wire logic action_code_lo,
   input wire logic bus_master,
   input wire logic data_read_n,
   input wire logic read_latch_enable,
   input wire logic [31:0] ld_in,
   output logic [31:0] ld_out,
   output logic ld_oe,
   input wire logic [31:0] md_in,
   output logic [31:0] md_out,
   output logic md_oe,
   input wire logic [3:0] mem_parity_bit_in,
   output logic [3:0] mem_parity_bit_out,
   output logic mem_parity_bit_oe,
   input wire logic [3:0] byte_check_enable_n,
   input wire logic channel_check_in_n,
   output logic channel_check_out_n,
   output logic nmi,
   output logic onboard_video_enable,
   output logic video_setup_n,
   input wire logic kbc_irq_pin_a,
   input wire logic kbc_irq_pin_b,
   output logic keyboard_irq_n,
   output logic aux_pointer_irq,
   output logic cmos_index_lo_wr_n,
   output logic cmos_index_hi_wr_n,
   output logic kbc_chip_select_n,
   output logic [NUM_DEC-1:0] prog_io_decode_n,
   output logic periph_bus_dir
);
   logic [7:0] port61;
   logic [7:0] port_e1;
   logic [7:0] port70;
   logic [7:0] video_ctrl;
   dbpio_dec_cfg_t dec_cfg [NUM_DEC];
   logic [NUM_DEC-1:0] dec_hit;
   dbpio_xbus_t xbus;
   dbpio_clr_state_t clr_state;
   logic parity_error;
   logic clear_error;
   logic [3:0] byte_bad;
   logic new_error;
   logic pin_a_prev;
   logic pin_b_prev;
   logic kbd_pending;
   logic aux_pending;
   logic kbd_data_read;
   logic ph_write;
   logic ph_read;
   logic [7:0] ph_addr;
   logic rd_wait;
   logic wr_now;
   logic [7:0] wbyte;
   logic md_to_ld;
   logic [1:0] action_code;

   assign xbus = '{addr: periph_addr_bit, rd_n: periph_io_read_n,
                   wr_n: periph_io_write_n, upper_ok_n: upper_addr_qualify_n};
   assign action_code = {action_code_hi, action_code_lo};

   // AHB address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_write <= 1'b0;
         ph_read <= 1'b0;
         ph_addr <= 8'h00;
      end
      else if (hready)
      begin
         ph_write <= hsel && htrans == DBPIO_HTRANS_NONSEQ && hwrite;
         ph_read <= hsel && htrans == DBPIO_HTRANS_NONSEQ && !hwrite;
         ph_addr <= haddr[7:0];
      end
      else if (rd_wait)
      begin
         ph_read <= ph_read;
      end
   end

   // Reads take one wait state to load read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_wait <= 1'b0;
      end
      else
      begin
         rd_wait <= ph_read && !rd_wait;
      end
   end

   assign hreadyout = !(ph_read && !rd_wait);
   assign hresp = 1'b0;
   assign wr_now = ph_write;
   assign wbyte = hwdata[7:0];

   // Read data mux, unmapped reads as zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= DBPIO_ZERO_WORD;
      end
      else if (ph_read && !rd_wait)
      begin
         hrdata <= DBPIO_ZERO_WORD;
         if (ph_addr == DBPIO_OFS_PORT61)
         begin
            hrdata[7:0] <= {parity_error, !channel_check_in_n, port61[5:0]};
         end
         else if (ph_addr == DBPIO_OFS_PORTE1)
         begin
            hrdata[7:0] <= port_e1;
         end
         else if (ph_addr == DBPIO_OFS_PORT70)
         begin
            hrdata[7:0] <= port70;
         end
         else if (ph_addr == DBPIO_OFS_VIDEO)
         begin
            hrdata[7:0] <= video_ctrl;
         end
         else if (ph_addr == DBPIO_OFS_STATUS)
         begin
            hrdata[3:0] <= {clr_state == CLR_IDLE, aux_pending, kbd_pending, parity_error};
         end
         else
         begin
            for (int i = 0; i < NUM_DEC; i++)
            begin
               if (ph_addr == DBPIO_OFS_SETUP0 + 8'(i) * DBPIO_OFS_DEC_STRIDE)
               begin
                  hrdata[7:0] <= dec_cfg[i].setup;
               end
               else if (ph_addr == DBPIO_OFS_DECODE0 + 8'(i) * DBPIO_OFS_DEC_STRIDE)
               begin
                  hrdata[9:0] <= dec_cfg[i].addr;
               end
            end
         end
      end
   end

   // Port style control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         port61 <= DBPIO_P61_RESET;
         port_e1 <= DBPIO_E1_RESET;
         port70 <= DBPIO_P70_RESET;
         video_ctrl <= DBPIO_VID_RESET;
      end
      else if (system_reset)
      begin
         port61 <= DBPIO_P61_RESET;
         port_e1 <= DBPIO_E1_RESET;
         port70 <= DBPIO_P70_RESET;
         video_ctrl <= DBPIO_VID_RESET;
      end
      else if (wr_now)
      begin
         if (ph_addr == DBPIO_OFS_PORT61)
         begin
            port61 <= {2'b00, wbyte[5:0]};
         end
         else if (ph_addr == DBPIO_OFS_PORTE1)
         begin
            port_e1 <= wbyte;
         end
         else if (ph_addr == DBPIO_OFS_PORT70)
         begin
            port70 <= wbyte;
         end
         else if (ph_addr == DBPIO_OFS_VIDEO)
         begin
            video_ctrl <= wbyte;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < NUM_DEC; i++)
         begin
            dec_cfg[i] <= '0;
         end
      end
      else if (system_reset)
      begin
         for (int i = 0; i < NUM_DEC; i++)
         begin
            dec_cfg[i] <= '0;
         end
      end
      else if (wr_now)
      begin
         for (int i = 0; i < NUM_DEC; i++)
         begin
            if (ph_addr == DBPIO_OFS_SETUP0 + 8'(i) * DBPIO_OFS_DEC_STRIDE)
            begin
               dec_cfg[i].setup <= wbyte;
            end
            else if (ph_addr == DBPIO_OFS_DECODE0 + 8'(i) * DBPIO_OFS_DEC_STRIDE)
            begin
               dec_cfg[i].addr <= hwdata[9:0];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clr_state <= CLR_IDLE;
      end
      else if (system_reset)
      begin
         clr_state <= CLR_IDLE;
      end
      else if (wr_now)
      begin
         case (clr_state)
            CLR_IDLE:
            begin
               if (ph_addr == DBPIO_OFS_PORTE1 && wbyte[DBPIO_E1_CHECK_EN])
               begin
                  clr_state <= CLR_E1_SET;
               end
            end
            CLR_E1_SET:
            begin
               if (ph_addr == DBPIO_OFS_PORTE1 && !wbyte[DBPIO_E1_CHECK_EN])
               begin
                  clr_state <= CLR_E1_DONE;
               end
            end
            CLR_E1_DONE:
            begin
               if (ph_addr == DBPIO_OFS_PORT61 && wbyte[DBPIO_P61_CHAN_EN] && wbyte[DBPIO_P61_PARITY_EN])
               begin
                  clr_state <= CLR_P61_SET;
               end
            end
            CLR_P61_SET:
            begin
               if (ph_addr == DBPIO_OFS_PORT61 && !wbyte[DBPIO_P61_CHAN_EN] && !wbyte[DBPIO_P61_PARITY_EN])
               begin
                  clr_state <= CLR_IDLE;
               end
            end
            default:
            begin
               clr_state <= CLR_IDLE;
            end
         endcase
      end
   end

   assign clear_error = wr_now && clr_state == CLR_P61_SET && ph_addr == DBPIO_OFS_PORT61
                        && !wbyte[DBPIO_P61_CHAN_EN] && !wbyte[DBPIO_P61_PARITY_EN];

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         byte_bad[i] = !byte_check_enable_n[i]
                       && dbpio_parity_bit(md_in[8*i +: 8]) != mem_parity_bit_in[i];
      end
      new_error = !data_read_n && read_latch_enable && |byte_bad
                  && port_e1[DBPIO_E1_CHECK_EN] && !port61[DBPIO_P61_PARITY_EN];
   end

   // sticky error, set wins over clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         parity_error <= 1'b0;
      end
      else if (system_reset)
      begin
         parity_error <= 1'b0;
      end
      else if (new_error)
      begin
         parity_error <= 1'b1;
      end
      else if (clear_error)
      begin
         parity_error <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         channel_check_out_n <= 1'b1;
         nmi <= 1'b0;
      end
      else if (system_reset)
      begin
         channel_check_out_n <= 1'b1;
         nmi <= 1'b0;
      end
      else
      begin
         channel_check_out_n <= !parity_error;
         nmi <= !port70[DBPIO_P70_NMI_MASK]
                && ((parity_error && !port61[DBPIO_P61_PARITY_EN])
                    || (!channel_check_in_n && !port61[DBPIO_P61_CHAN_EN]));
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         onboard_video_enable <= 1'b0;
         video_setup_n <= 1'b1;
      end
      else
      begin
         onboard_video_enable <= !system_reset && video_ctrl[DBPIO_VID_ENABLE];
         video_setup_n <= system_reset || !video_ctrl[DBPIO_VID_SETUP];
      end
   end

   assign kbd_data_read = !periph_io_read_n && periph_addr_bit == DBPIO_IO_KBD_DATA;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_a_prev <= 1'b0;
         pin_b_prev <= 1'b0;
         kbd_pending <= 1'b0;
         aux_pending <= 1'b0;
      end
      else if (system_reset)
      begin
         pin_a_prev <= kbc_irq_pin_a;
         pin_b_prev <= kbc_irq_pin_b;
         kbd_pending <= 1'b0;
         aux_pending <= 1'b0;
      end
      else
      begin
         pin_a_prev <= kbc_irq_pin_a;
         pin_b_prev <= kbc_irq_pin_b;
         if (kbc_irq_pin_a && !pin_a_prev)
         begin
            kbd_pending <= 1'b1;
         end
         else if (kbd_data_read)
         begin
            kbd_pending <= 1'b0;
         end
         if (kbc_irq_pin_b && !pin_b_prev)
         begin
            aux_pending <= 1'b1;
         end
         else if (kbd_data_read)
         begin
            aux_pending <= 1'b0;
         end
      end
   end

   assign keyboard_irq_n = !kbd_pending;
   assign aux_pointer_irq = aux_pending;

   for (genvar g = 0; g < NUM_DEC; g++)
   begin : g_dec
      dbpio_prog_decode u_dec
      (
         .cfg(dec_cfg[g]),
         .xbus(xbus),
         .hit(dec_hit[g])
      );
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmos_index_lo_wr_n <= 1'b1;
         cmos_index_hi_wr_n <= 1'b1;
         kbc_chip_select_n <= 1'b1;
         prog_io_decode_n <= '1;
         periph_bus_dir <= 1'b1;
      end
      else if (system_reset)
      begin
         cmos_index_lo_wr_n <= 1'b1;
         cmos_index_hi_wr_n <= 1'b1;
         kbc_chip_select_n <= 1'b1;
         prog_io_decode_n <= '1;
         periph_bus_dir <= 1'b1;
      end
      else
      begin
         cmos_index_lo_wr_n <= !(!periph_io_write_n && periph_addr_bit == DBPIO_IO_CMOS_LO);
         cmos_index_hi_wr_n <= !(!periph_io_write_n && periph_addr_bit == DBPIO_IO_CMOS_HI);
         kbc_chip_select_n <= !((!periph_io_read_n || !periph_io_write_n)
                               && (periph_addr_bit == DBPIO_IO_KBD_DATA
                                   || periph_addr_bit == DBPIO_IO_KBD_CMD));
         prog_io_decode_n <= ~dec_hit;
         periph_bus_dir <= !(!periph_io_read_n && dec_hit == '0);
      end
   end

   assign md_to_ld = bus_master ? (action_code == DBPIO_AC_STRAIGHT && data_read_n) : !data_read_n;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ld_out <= DBPIO_ZERO_WORD;
         md_out <= DBPIO_ZERO_WORD;
         ld_oe <= 1'b0;
         md_oe <= 1'b0;
         mem_parity_bit_out <= 4'h0;
         mem_parity_bit_oe <= 1'b0;
      end
      else if (system_reset)
      begin
         ld_oe <= 1'b0;
         md_oe <= 1'b0;
         mem_parity_bit_oe <= 1'b0;
      end
      else
      begin
         ld_oe <= md_to_ld;
         md_oe <= !md_to_ld;
         mem_parity_bit_oe <= data_read_n;
         if (md_to_ld && (bus_master || read_latch_enable))
         begin
            ld_out <= md_in;
         end
         if (!md_to_ld)
         begin
            md_out <= ld_in;
            for (int i = 0; i < 4; i++)
            begin
               mem_parity_bit_out[i] <= dbpio_parity_bit(ld_in[8*i +: 8]);
            end
         end
      end
   end
endmodule : dbpio_top

/* File: dbpio_sva.sv */
module dbpio_sva
   import dbpio_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic system_reset,
   input wire logic [16:0] periph_addr_bit,
   input wire logic periph_io_read_n,
   input wire logic periph_io_write_n,
   input wire logic kbc_irq_pin_a,
   input wire logic kbc_irq_pin_b,
   input wire logic data_read_n,
   input wire logic bus_master,
   input wire logic [31:0] ld_in,
   input wire logic [3:0] mem_parity_bit_out,
   input wire logic mem_parity_bit_oe,
   input wire logic keyboard_irq_n,
   input wire logic aux_pointer_irq,
   input wire logic cmos_index_lo_wr_n,
   input wire logic cmos_index_hi_wr_n,
   input wire logic kbc_chip_select_n,
   input wire logic nmi,
   input wire logic periph_bus_dir
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] ld_q;
   wire logic kbd_acc = (!periph_io_read_n || !periph_io_write_n)
      && (periph_addr_bit == DBPIO_IO_KBD_DATA || periph_addr_bit == DBPIO_IO_KBD_CMD);
   wire logic rd60 = !periph_io_read_n && periph_addr_bit == DBPIO_IO_KBD_DATA;
   wire logic pins_low = !kbc_irq_pin_a && !kbc_irq_pin_b;
   // Previous write data
   always_ff @(posedge hclk)
   begin
      ld_q <= ld_in;
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   AST_PAR_GEN: assert property (data_read_n && !bus_master && !system_reset |=> mem_parity_bit_oe &&
      mem_parity_bit_out == {~^ld_q[31:24], ~^ld_q[23:16], ~^ld_q[15:8], ~^ld_q[7:0]})
      else $error("parity bits wrong");
   AST_PAR_FLOAT: assert property (!data_read_n |=> !mem_parity_bit_oe)
      else $error("parity driven in read");
   AST_CMOS_LO: assert property (!periph_io_write_n && periph_addr_bit == DBPIO_IO_CMOS_LO && !system_reset
      |=> !cmos_index_lo_wr_n && cmos_index_hi_wr_n)
      else $error("index strobe wrong");
   AST_CMOS_IDLE: assert property (periph_io_write_n [*2] |-> cmos_index_lo_wr_n && cmos_index_hi_wr_n)
      else $error("index strobe without write");
   AST_KBC_CS: assert property (kbd_acc && !system_reset |=> !kbc_chip_select_n)
      else $error("chip select missing");
   AST_KBD_IRQ: assert property ($rose(kbc_irq_pin_a) && periph_io_read_n && !system_reset
      ##1 periph_io_read_n && !system_reset |-> ##[0:1] !keyboard_irq_n)
      else $error("keyboard irq missing");
   AST_AUX_IRQ: assert property ($rose(kbc_irq_pin_b) && periph_io_read_n && !system_reset
      ##1 periph_io_read_n && !system_reset |-> ##[0:1] aux_pointer_irq)
      else $error("aux irq missing");
   AST_IRQ_CLR: assert property (pins_low ##1 (rd60 && pins_low) [*2] |=> keyboard_irq_n && !aux_pointer_irq)
      else $error("irq not cleared");
   AST_DIR_IDLE: assert property (periph_io_read_n && !system_reset |=> periph_bus_dir)
      else $error("direction low without read");
   AST_SYS_RST: assert property (system_reset |=> keyboard_irq_n && !aux_pointer_irq && !nmi
      && !mem_parity_bit_oe && periph_bus_dir && kbc_chip_select_n && cmos_index_lo_wr_n)
      else $error("outputs active in reset");
endmodule : dbpio_sva

/* File: dbpio_xbus_model.sv */
module dbpio_xbus_model
   import dbpio_pkg::*;
(
   input wire logic hclk,
   output dbpio_xbus_t xbus
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      xbus = {17'h1_5555, 1'b1, 1'b1, 1'b1};
   end
   task automatic io_on(input logic [16:0] a, input logic w, input logic up_n);
      @(posedge hclk);
      xbus <= {a, w, ~w, up_n};
   endtask : io_on
   task automatic io_off();
      @(posedge hclk);
      xbus <= {~xbus.addr, 2'b11, ~xbus.upper_ok_n};
   endtask : io_off
endmodule : dbpio_xbus_model

/* File: dbpio_tb_top.sv */
module dbpio_tb_top
   import dbpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hreadyout, rdy_s, mem_parity_bit_oe, channel_check_out_n, nmi, onboard_video_enable;
   logic keyboard_irq_n, aux_pointer_irq, cmos_index_lo_wr_n, cmos_index_hi_wr_n, kbc_chip_select_n, periph_bus_dir;
   logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, system_reset = 1'b0, data_read_n = 1'b1, bus_master = 1'b0;
   logic read_latch_enable = 1'b0, channel_check_in_n = 1'b1, kbc_irq_pin_a = 1'b0, kbc_irq_pin_b = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, ld_in = 32'h0000_0000, md_in = 32'h0000_0000;
   logic [3:0] mem_parity_bit_in = 4'hF, byte_check_enable_n = 4'hF, mem_parity_bit_out;
   logic [31:0] hrdata, dat_s, rq, ld_out;
   logic [2:0] prog_io_decode_n;
   logic ld_oe;
   dbpio_xbus_t xb_sig;
   int err_total = 0, checks = 0, cyc = 0;

   dbpio_xbus_model xb (.hclk, .xbus(xb_sig));
   dbpio_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp(), .hrdata, .system_reset, .periph_addr_bit(xb_sig.addr), .periph_io_read_n(xb_sig.rd_n),
      .periph_io_write_n(xb_sig.wr_n), .upper_addr_qualify_n(xb_sig.upper_ok_n), .action_code_hi(1'b0),
      .action_code_lo(1'b0), .bus_master, .data_read_n, .read_latch_enable, .ld_in, .ld_out, .ld_oe,
      .md_in, .md_out(), .md_oe(), .mem_parity_bit_in, .mem_parity_bit_out, .mem_parity_bit_oe,
      .byte_check_enable_n, .channel_check_in_n, .channel_check_out_n, .nmi, .onboard_video_enable,
      .video_setup_n(), .kbc_irq_pin_a, .kbc_irq_pin_b, .keyboard_irq_n, .aux_pointer_irq, .cmos_index_lo_wr_n,
      .cmos_index_hi_wr_n, .kbc_chip_select_n, .prog_io_decode_n, .periph_bus_dir);

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Values seen by the next rising edge
   always @(negedge hclk)
   begin
      rdy_s = hreadyout;
      dat_s = hrdata;
   end
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t word %h exp %h", $time, got, exp);
      end
   endtask : cmp_w
   task automatic cmp_b(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t bit %b exp %b", $time, got, exp);
      end
   endtask : cmp_b
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= DBPIO_HTRANS_NONSEQ;
      hsel <= 1'b1;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      rq = dat_s;
   endtask : ahb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0000_0000);
      cmp_w(rq, e);
   endtask : rd_chk
   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : settle
   task automatic io(input logic [16:0] a, input logic w, input logic up_n);
      xb.io_on(a, w, up_n);
      settle(2);
   endtask : io
   task automatic dec_case(input int i, input logic [7:0] setup, input logic [16:0] a, input logic w,
      input logic up_n, input logic exp_n);
      ahb(DBPIO_OFS_SETUP0 + 8'(i) * DBPIO_OFS_DEC_STRIDE, 1'b1, {24'h00_0000, setup});
      ahb(DBPIO_OFS_DECODE0 + 8'(i) * DBPIO_OFS_DEC_STRIDE, 1'b1, 32'h0000_0030);
      io(a, w, up_n);
      cmp_b(prog_io_decode_n[i], exp_n);
      cmp_b(periph_bus_dir, w | ~exp_n);
      xb.io_off();
      ahb(DBPIO_OFS_SETUP0 + 8'(i) * DBPIO_OFS_DEC_STRIDE, 1'b1, 32'h0000_0000);
   endtask : dec_case

   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(DBPIO_OFS_PORT70, 32'h0000_0080);
      rd_chk(DBPIO_OFS_VIDEO, 32'h0000_0001);
      rd_chk(DBPIO_OFS_PORT61, 32'h0000_0000);
      rd_chk(DBPIO_OFS_STATUS, 32'h0000_0008);
      rd_chk(8'h18, 32'h0000_0000);
      cmp_b(onboard_video_enable, 1'b1);
      ahb(DBPIO_OFS_VIDEO, 1'b1, 32'h0000_0000);
      settle(2);
      cmp_b(onboard_video_enable, 1'b0);
      ld_in <= 32'h0103_0700;
      settle(2);
      cmp_b(mem_parity_bit_oe, 1'b1);
      cmp_w({28'h000_0000, mem_parity_bit_out}, 32'h0000_0005);
      ahb(DBPIO_OFS_PORTE1, 1'b1, 32'h0000_0001);
      md_in <= 32'h0000_0003;
      mem_parity_bit_in <= 4'hE;
      byte_check_enable_n <= 4'h1;
      data_read_n <= 1'b0;
      read_latch_enable <= 1'b1;
      settle(4);
      cmp_b(mem_parity_bit_oe, 1'b0);
      cmp_b(channel_check_out_n, 1'b1);
      byte_check_enable_n <= 4'hE;
      settle(4);
      cmp_b(channel_check_out_n, 1'b0);
      cmp_b(nmi, 1'b0);
      data_read_n <= 1'b1;
      read_latch_enable <= 1'b0;
      ahb(DBPIO_OFS_PORT70, 1'b1, 32'h0000_0000);
      settle(3);
      cmp_b(nmi, 1'b1);
      rd_chk(DBPIO_OFS_STATUS, 32'h0000_0001);
      ahb(DBPIO_OFS_PORTE1, 1'b1, 32'h0000_0001);
      ahb(DBPIO_OFS_PORTE1, 1'b1, 32'h0000_0000);
      ahb(DBPIO_OFS_PORT61, 1'b1, 32'h0000_000C);
      settle(3);
      cmp_b(channel_check_out_n, 1'b0);
      ahb(DBPIO_OFS_PORT61, 1'b1, 32'h0000_0000);
      settle(3);
      cmp_b(channel_check_out_n, 1'b1);
      cmp_b(nmi, 1'b0);
      channel_check_in_n <= 1'b0;
      settle(3);
      cmp_b(nmi, 1'b1);
      channel_check_in_n <= 1'b1;
      kbc_irq_pin_a <= 1'b1;
      settle(3);
      cmp_b(keyboard_irq_n, 1'b0);
      kbc_irq_pin_a <= 1'b0;
      kbc_irq_pin_b <= 1'b1;
      settle(3);
      cmp_b(aux_pointer_irq, 1'b1);
      kbc_irq_pin_b <= 1'b0;
      settle(2);
      io(DBPIO_IO_KBD_DATA, 1'b0, 1'b1);
      cmp_b(keyboard_irq_n, 1'b1);
      cmp_b(aux_pointer_irq, 1'b0);
      cmp_b(kbc_chip_select_n, 1'b0);
      cmp_b(periph_bus_dir, 1'b0);
      xb.io_off();
      io(DBPIO_IO_CMOS_LO, 1'b1, 1'b1);
      cmp_b(cmos_index_lo_wr_n, 1'b0);
      cmp_b(periph_bus_dir, 1'b1);
      xb.io_off();
      io(DBPIO_IO_CMOS_HI, 1'b1, 1'b1);
      cmp_b(cmos_index_hi_wr_n, 1'b0);
      xb.io_off();
      io(DBPIO_IO_KBD_CMD, 1'b1, 1'b1);
      cmp_b(kbc_chip_select_n, 1'b0);
      xb.io_off();
      dec_case(0, 8'h03, 17'h0_0037, 1'b0, 1'b1, 1'b0);
      dec_case(0, 8'h03, 17'h0_0038, 1'b0, 1'b1, 1'b1);
      dec_case(1, 8'h01, 17'h0_0031, 1'b0, 1'b1, 1'b1);
      dec_case(1, 8'h01, 17'h0_0430, 1'b0, 1'b0, 1'b1);
      dec_case(2, 8'h05, 17'h0_0430, 1'b0, 1'b0, 1'b0);
      dec_case(2, 8'h05, 17'h0_0430, 1'b0, 1'b1, 1'b1);
      dec_case(0, 8'h09, 17'h0_0030, 1'b0, 1'b1, 1'b1);
      dec_case(0, 8'h09, 17'h0_0030, 1'b1, 1'b1, 1'b0);
      dec_case(1, 8'h11, 17'h0_0030, 1'b1, 1'b1, 1'b1);
      bus_master <= 1'b1;
      md_in <= 32'h1234_5678;
      settle(2);
      cmp_b(ld_oe, 1'b1);
      cmp_w(ld_out, 32'h1234_5678);
      bus_master <= 1'b0;
      system_reset <= 1'b1;
      settle(2);
      system_reset <= 1'b0;
      settle(1);
      cmp_b(onboard_video_enable, 1'b1);
      rd_chk(DBPIO_OFS_PORT70, 32'h0000_0080);
      tally_and_finish();
   end
endmodule : dbpio_tb_top

bind dbpio_top dbpio_sva chk (.hclk, .hresetn, .system_reset, .periph_addr_bit, .periph_io_read_n,
   .periph_io_write_n, .kbc_irq_pin_a, .kbc_irq_pin_b, .data_read_n, .bus_master, .ld_in, .mem_parity_bit_out,
   .mem_parity_bit_oe, .keyboard_irq_n, .aux_pointer_irq, .cmos_index_lo_wr_n, .cmos_index_hi_wr_n,
   .kbc_chip_select_n, .nmi, .periph_bus_dir);
